// *** verilog/motor_cmd_pkg.sv ***
// Purpose: Shared constants and types for the motor run command decoder.
// Assumes: Digital inputs are sampled on the 50 MHz control clock.
// Notes:   Function and method codes match the drive's parameter values.
//
// Functional notes
// RL1 - Command source 2 means start, stop and direction come from inputs.
// RL2 - Five input control methods: three two-wire, two three-wire.
// RL3 - Method code 0 selects two-wire methods 1 or 2; factory default.
// RL4 - Two-wire methods treat both command inputs as held levels.
// RL5 - Two-wire method 1: one input runs/stops, other picks direction only.
// RL6 - Two-wire method 1: run low gives ramp-down stop, reverse ignored.
// RL7 - Two-wire method 1, run high: reverse picks setpoint or negated one.
// RL8 - Input 0 carries run by default, function code 1.
// RL9 - Input 1 carries reverse by default in method 1, function code 12.
// RL10 - Any input may take run or reverse by writing the same code.
// RL11 - Two-wire method 3 reverses any time; both active differs from 2.
// RL12 - Three-wire methods act on rising edges as well as levels.
// RL13 - Clockwise command yields clockwise output phase sequence.
// RL14 - Two-wire method 2, both high: first active keeps priority.
// RL15 - Two-wire method 2 accepts reversal only after reaching 0 Hz.
// RL16 - Method code 1 selects two-wire method 3; both high stops.
// RL17 - Inputs are synchronised; edges compare current and previous sample.
// RL18 - Other command sources: decoded input commands are ignored.

`default_nettype none

package motor_cmd_pkg;

	localparam int          NUM_DI        = 4;
	localparam int          CODE_W        = 8;
	localparam int          SRC_W         = 4;
	localparam int          METHOD_W      = 3;

	// -------------------------------------------------------------------
	// Setting codes
	// -------------------------------------------------------------------
	localparam logic [SRC_W-1:0]    SRC_DIGITAL   = 4'h2;
	localparam logic [METHOD_W-1:0] WCM_TWO_1_2   = 3'h0;
	localparam logic [METHOD_W-1:0] WCM_TWO_3     = 3'h1;
	localparam logic [METHOD_W-1:0] WCM_THREE_1   = 3'h2;
	localparam logic [METHOD_W-1:0] WCM_THREE_2   = 3'h3;
	localparam logic [METHOD_W-1:0] WCM_DEFAULT   = WCM_TWO_1_2;

	// Input function codes
	localparam logic [CODE_W-1:0]   FC_ON         = 8'h01;
	localparam logic [CODE_W-1:0]   FC_SECOND     = 8'h02;
	localparam logic [CODE_W-1:0]   FC_REVERSE    = 8'h0c;

	// Factory assignment of inputs 0 and 1
	localparam logic [CODE_W-1:0]   DEF_IN0_CODE  = FC_ON;
	localparam logic [CODE_W-1:0]   DEF_IN1_CODE  = FC_REVERSE;

	typedef enum logic [1:0] {ST_STOP, ST_CW, ST_CCW} motor_state_e;

	// Decoded command functions
	typedef struct packed {
		logic on;
		logic second;
		logic rev;
	} fn_s;

	// Command to the ramp generator and modulator
	typedef struct packed {
		logic run;
		logic reverse;
		logic ramp_down_stop;
		logic phase_cw;
	} cmd_s;

	localparam cmd_s CMD_RESET = '{run: 1'b0, reverse: 1'b0,
		ramp_down_stop: 1'b1, phase_cw: 1'b0};

endpackage

`default_nettype wire

// *** verilog/motor_run_command_decoder.sv ***
// Purpose: Decode digital input levels and edges into run/stop/direction.
// Assumes: Setting ports are static from the controller; i_at_standstill
//          comes from the ramp generator on the same clock.
// Notes:   Output command lags a pin change by three clock edges.

`default_nettype none

module motor_run_command_decoder #(
	parameter int NUM_DI = motor_cmd_pkg::NUM_DI
) (
	input  wire logic                                   i_clk,
	input  wire logic                                   i_rst_n,
	input  wire logic [NUM_DI-1:0]                      i_din,
	input  wire logic [motor_cmd_pkg::SRC_W-1:0]        i_command_source_select,
	input  wire logic [motor_cmd_pkg::METHOD_W-1:0]     i_wire_control_method,
	input  wire logic [NUM_DI-1:0][motor_cmd_pkg::CODE_W-1:0] i_input_function_code,
	input  wire logic                                   i_at_standstill,
	output var motor_cmd_pkg::cmd_s                     o_cmd,
	output logic [1:0]                                  o_state
);

	// -------------------------------------------------------------------
	// Input synchroniser
	// -------------------------------------------------------------------
	logic [NUM_DI-1:0] din_s1_r;
	logic [NUM_DI-1:0] din_s2_r;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			din_s1_r <= '0;
			din_s2_r <= '0;
		end else begin
			din_s1_r <= i_din; // RL17
			din_s2_r <= din_s1_r;
		end
	end

	// -------------------------------------------------------------------
	// Function decode
	// -------------------------------------------------------------------
	// Any input carrying a code contributes; several inputs may share one.
	motor_cmd_pkg::fn_s fn;
	logic               has_rev_code;

	always_comb begin
		fn           = '0;
		has_rev_code = 1'b0;
		for (int i = 0; i < NUM_DI; i++) begin
			if (i_input_function_code[i] == motor_cmd_pkg::FC_ON) begin
				fn.on = fn.on | din_s2_r[i]; // RL8 RL10
			end
			if (i_input_function_code[i] == motor_cmd_pkg::FC_SECOND) begin
				fn.second = fn.second | din_s2_r[i];
			end
			if (i_input_function_code[i] == motor_cmd_pkg::FC_REVERSE) begin
				fn.rev       = fn.rev | din_s2_r[i]; // RL9 RL10
				has_rev_code = 1'b1;
			end
		end
	end

	motor_cmd_pkg::fn_s fn_prev_r;
	motor_cmd_pkg::fn_s fn_rise;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			fn_prev_r <= '0;
		end else begin
			fn_prev_r <= fn;
		end
	end

	assign fn_rise = fn & ~fn_prev_r; // RL17

	// -------------------------------------------------------------------
	// Method selection
	// -------------------------------------------------------------------
	// Code 0 covers two methods: a reverse-coded input means method 1,
	// otherwise the second input is a counter-clockwise run (method 2).
	logic [motor_cmd_pkg::METHOD_W-1:0] method;
	logic                               two_m1;
	logic                               src_dig;

	always_comb begin
		method = i_wire_control_method;
		if (method > motor_cmd_pkg::WCM_THREE_2) begin // RL2
			method = motor_cmd_pkg::WCM_DEFAULT; // RL3
		end
	end

	assign two_m1  = (method == motor_cmd_pkg::WCM_TWO_1_2) && has_rev_code;
	assign src_dig = (i_command_source_select == motor_cmd_pkg::SRC_DIGITAL);

	// -------------------------------------------------------------------
	// Run state machine
	// -------------------------------------------------------------------
	motor_cmd_pkg::motor_state_e state_r;
	motor_cmd_pkg::motor_state_e state_nxt;
	motor_cmd_pkg::motor_state_e last_dir_r;
	motor_cmd_pkg::motor_state_e last_dir_nxt;
	motor_cmd_pkg::cmd_s         cmd_r;
	motor_cmd_pkg::cmd_s         cmd_nxt;
	logic                        cw_ok;
	logic                        ccw_ok;

	always_comb begin
		state_nxt    = state_r;
		last_dir_nxt = last_dir_r;
		// Method 2: reversal waits for standstill so a spinning motor is
		// never driven straight into the opposite direction.
		cw_ok  = (last_dir_r != motor_cmd_pkg::ST_CCW) || i_at_standstill;
		ccw_ok = (last_dir_r != motor_cmd_pkg::ST_CW) || i_at_standstill;
		if (src_dig) begin // RL1 RL18
			if (method == motor_cmd_pkg::WCM_TWO_1_2 && two_m1) begin
				// Held levels: on starts/stops, rev picks direction only
				if (!fn.on) begin
					state_nxt = motor_cmd_pkg::ST_STOP; // RL4 RL5 RL6
				end else if (fn.rev) begin
					state_nxt = motor_cmd_pkg::ST_CCW; // RL7
				end else begin
					state_nxt = motor_cmd_pkg::ST_CW; // RL7
				end
			end else if (method == motor_cmd_pkg::WCM_TWO_1_2) begin
				case (state_r)
					motor_cmd_pkg::ST_CW: begin
						if (!fn.on) begin
							state_nxt = motor_cmd_pkg::ST_STOP;
						end
					end
					motor_cmd_pkg::ST_CCW: begin
						if (!fn.second) begin
							state_nxt = motor_cmd_pkg::ST_STOP;
						end
					end
					default: begin
						if (fn.on && cw_ok) begin
							state_nxt = motor_cmd_pkg::ST_CW; // RL15
						end else if (fn.second && ccw_ok) begin
							state_nxt = motor_cmd_pkg::ST_CCW; // RL15
						end
					end
				endcase // RL14
			end else if (method == motor_cmd_pkg::WCM_TWO_3) begin
				if (fn.on == fn.second) begin
					state_nxt = motor_cmd_pkg::ST_STOP; // RL16 RL11
				end else if (fn.on) begin
					state_nxt = motor_cmd_pkg::ST_CW; // RL11
				end else begin
					state_nxt = motor_cmd_pkg::ST_CCW;
				end
			end else if (method == motor_cmd_pkg::WCM_THREE_1) begin
				// Enable level, clockwise and counter-clockwise edges
				if (!fn.on || (fn.second && fn.rev)) begin
					state_nxt = motor_cmd_pkg::ST_STOP;
				end else if (fn_rise.second && !fn.rev) begin
					state_nxt = motor_cmd_pkg::ST_CW; // RL12
				end else if (fn_rise.rev && !fn.second) begin
					state_nxt = motor_cmd_pkg::ST_CCW; // RL12
				end
			end else begin
				// Enable level, start edge, direction level
				if (!fn.on) begin
					state_nxt = motor_cmd_pkg::ST_STOP;
				end else if (state_r != motor_cmd_pkg::ST_STOP || fn_rise.second) begin
					state_nxt = fn.rev ? motor_cmd_pkg::ST_CCW // RL12
						: motor_cmd_pkg::ST_CW;
				end
			end
		end
		if (state_nxt != motor_cmd_pkg::ST_STOP) begin
			last_dir_nxt = state_nxt;
		end

		cmd_nxt.run            = (state_nxt != motor_cmd_pkg::ST_STOP);
		cmd_nxt.reverse        = (state_nxt == motor_cmd_pkg::ST_CCW);
		cmd_nxt.ramp_down_stop = (state_nxt == motor_cmd_pkg::ST_STOP);
		cmd_nxt.phase_cw       = (state_nxt == motor_cmd_pkg::ST_CW); // RL13
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state_r    <= motor_cmd_pkg::ST_STOP;
			last_dir_r <= motor_cmd_pkg::ST_STOP;
			cmd_r      <= motor_cmd_pkg::CMD_RESET;
		end else begin
			state_r    <= state_nxt;
			last_dir_r <= last_dir_nxt;
			cmd_r      <= cmd_nxt;
		end
	end

	assign o_cmd   = cmd_r;
	assign o_state = state_r;

	// -------------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------------
	chk_src_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL18
		!src_dig |=> $stable(cmd_r))
		else $error("Command changed while inputs not selected");

	chk_m1_stop: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL6
		src_dig && two_m1 && !fn.on |=> cmd_r.ramp_down_stop && !cmd_r.run)
		else $error("Method 1 run low did not stop");

	chk_m1_dir: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL7
		src_dig && two_m1 && fn.on |=> cmd_r.run && (cmd_r.reverse == $past(fn.rev)))
		else $error("Method 1 direction wrong");

	chk_m3_both: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL16
		src_dig && method == motor_cmd_pkg::WCM_TWO_3 && fn.on && fn.second
		|=> cmd_r.ramp_down_stop)
		else $error("Method 3 both high did not stop");

	chk_m2_first: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL14
		src_dig && method == motor_cmd_pkg::WCM_TWO_1_2 && !two_m1
		&& state_r == motor_cmd_pkg::ST_CW && fn.on
		|=> state_r == motor_cmd_pkg::ST_CW)
		else $error("Method 2 lost first active priority");

	chk_m2_wait: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL15
		src_dig && method == motor_cmd_pkg::WCM_TWO_1_2 && !two_m1
		&& state_r == motor_cmd_pkg::ST_STOP
		&& last_dir_r == motor_cmd_pkg::ST_CW && !i_at_standstill
		|=> state_r != motor_cmd_pkg::ST_CCW)
		else $error("Method 2 reversed before standstill");

	chk_edge_cw: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL12
		src_dig && method == motor_cmd_pkg::WCM_THREE_1 && fn.on
		&& fn_rise.second && !fn.rev
		|=> cmd_r.run && cmd_r.phase_cw ##1 ($stable(cmd_r.run)
		|| !$past(fn.on) || $past(fn.second && fn.rev)))
		else $error("Three-wire edge did not start clockwise");

	chk_phase_cw: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL13
		cmd_r.phase_cw == (cmd_r.run && !cmd_r.reverse))
		else $error("Phase sequence does not follow direction");

	chk_sync_lag: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL17
		$rose(din_s1_r[0]) |=> din_s2_r[0])
		else $error("Synchroniser stage missing");

endmodule

`default_nettype wire

// *** dv/switch_panel.sv ***
// Purpose: Far-side model: switch contacts wired to the drive's inputs.
// Assumes: The bench sets the contact levels off the rising clock edge.
// Notes:   Contacts are plain held levels; no bounce is modelled.

`default_nettype none

module switch_panel #(
	parameter int NUM_DI = motor_cmd_pkg::NUM_DI
) (
	input  wire logic [NUM_DI-1:0] i_contact,
	output logic      [NUM_DI-1:0] o_din
);
	timeunit 1ns;
	timeprecision 1ps;

	// Held levels for as long as the command applies
	assign o_din = i_contact;
endmodule

`default_nettype wire

// *** dv/motor_run_command_decoder_bench.sv ***
// Purpose: Self-checking bench for the motor run command decoder.
// Assumes: Settings change only between checks; outputs lag pins 3 edges.
// Notes:   Table rows hold level cases; history cases are written by hand.

`default_nettype none

module motor_run_command_decoder_bench;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	logic                  i_clk;
	logic                  i_rst_n;
	logic [3:0]            contact;
	logic [3:0]            din;
	logic [3:0]            src;
	logic [2:0]            meth;
	logic [3:0][7:0]       codes;
	logic                  sst;
	motor_cmd_pkg::cmd_s   o_cmd;
	logic [1:0]            o_state;
	int                    err_total;
	int                    checked;

	typedef struct packed {
		logic [2:0]      meth;
		logic [3:0][7:0] codes;
		logic [3:0]      din;
		logic            sst;
		logic            run;
		logic            rev;
		logic [1:0]      st;
	} row_s;

	localparam logic [3:0][7:0] M1 = {8'h00, 8'h00, 8'h0c, 8'h01};
	localparam logic [3:0][7:0] M2 = {8'h00, 8'h00, 8'h02, 8'h01};
	localparam logic [3:0][7:0] T1 = {8'h00, 8'h0c, 8'h02, 8'h01};
	localparam logic [3:0][7:0] R3 = {8'h01, 8'h00, 8'h0c, 8'h00};

	row_s rows [9] = '{
		'{3'h0, M1, 4'h1, 1'b0, 1'b1, 1'b0, 2'h1},
		'{3'h0, M1, 4'h3, 1'b0, 1'b1, 1'b1, 2'h2},
		'{3'h0, M1, 4'h2, 1'b0, 1'b0, 1'b0, 2'h0},
		'{3'h0, M1, 4'h0, 1'b0, 1'b0, 1'b0, 2'h0},
		'{3'h0, R3, 4'h8, 1'b0, 1'b1, 1'b0, 2'h1},
		'{3'h5, M1, 4'h3, 1'b0, 1'b1, 1'b1, 2'h2},
		'{3'h1, M2, 4'h1, 1'b0, 1'b1, 1'b0, 2'h1},
		'{3'h1, M2, 4'h2, 1'b0, 1'b1, 1'b1, 2'h2},
		'{3'h1, M2, 4'h3, 1'b0, 1'b0, 1'b0, 2'h0}
	};

	switch_panel u_panel (.i_contact(contact), .o_din(din));

	motor_run_command_decoder u_dut (
		.i_clk                   (i_clk),
		.i_rst_n                 (i_rst_n),
		.i_din                   (din),
		.i_command_source_select (src),
		.i_wire_control_method   (meth),
		.i_input_function_code   (codes),
		.i_at_standstill         (sst),
		.o_cmd                   (o_cmd),
		.o_state                 (o_state)
	);

	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic motor_cmd_pkg::cmd_s ex(input logic r, input logic v);
		ex = '{run: r, reverse: v, ramp_down_stop: !r, phase_cw: r & !v};
	endfunction

	task automatic chk(input string what, input logic [7:0] seen,
			input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic expect_out(input logic r, input logic v,
			input logic [1:0] st);
		chk("o_cmd", {4'h0, o_cmd}, {4'h0, ex(r, v)});
		chk("o_state", {6'h00, o_state}, {6'h00, st});
	endtask

	// Set the contacts at a falling edge, then let n falling edges pass
	task automatic step(input logic [3:0] d, input int n);
		contact = d;
		repeat (n) @(negedge i_clk);
	endtask

	task automatic end_of_test;
		if (err_total == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------------
	initial begin
		err_total = 0;
		checked = 0;
		i_rst_n = 1'b0;
		contact = 4'h0;
		src = motor_cmd_pkg::SRC_DIGITAL;
		meth = motor_cmd_pkg::WCM_DEFAULT;
		codes = M1;
		sst = 1'b1;
		repeat (3) @(negedge i_clk);
		chk("reset cmd", {4'h0, o_cmd}, {4'h0, motor_cmd_pkg::CMD_RESET});
		chk("reset state", {6'h00, o_state}, 8'h00);
		i_rst_n = 1'b1;
		for (int k = 0; k < 9; k++) begin
			meth = rows[k].meth;
			codes = rows[k].codes;
			sst = rows[k].sst;
			step(rows[k].din, 4);
			expect_out(rows[k].run, rows[k].rev, rows[k].st);
		end
		// Pin to output latency: three rising edges
		meth = 3'h0;
		codes = M1;
		sst = 1'b1;
		step(4'h0, 4);
		step(4'h1, 2);
		expect_out(1'b0, 1'b0, 2'h0);
		step(4'h1, 1);
		expect_out(1'b1, 1'b0, 2'h1);
		// Two-wire method 2: first signal keeps priority, reversal gated
		codes = M2;
		step(4'h0, 4);
		step(4'h1, 4);
		expect_out(1'b1, 1'b0, 2'h1);
		step(4'h3, 4);
		expect_out(1'b1, 1'b0, 2'h1);
		sst = 1'b0;
		step(4'h2, 4);
		expect_out(1'b0, 1'b0, 2'h0);
		sst = 1'b1;
		step(4'h2, 4);
		expect_out(1'b1, 1'b1, 2'h2);
		// Three-wire method 1: edges start each direction
		meth = 3'h2;
		codes = T1;
		step(4'h0, 4);
		step(4'h1, 4);
		expect_out(1'b0, 1'b0, 2'h0);
		step(4'h3, 4);
		expect_out(1'b1, 1'b0, 2'h1);
		step(4'h1, 4);
		step(4'h5, 4);
		expect_out(1'b1, 1'b1, 2'h2);
		step(4'h0, 4);
		expect_out(1'b0, 1'b0, 2'h0);
		// Three-wire method 2: start edge, then direction follows level
		meth = 3'h3;
		step(4'h5, 4);
		expect_out(1'b0, 1'b0, 2'h0);
		step(4'h7, 4);
		expect_out(1'b1, 1'b1, 2'h2);
		step(4'h3, 4);
		expect_out(1'b1, 1'b0, 2'h1);
		// Another command source freezes the outputs
		meth = 3'h0;
		codes = M1;
		step(4'h1, 4);
		src = 4'h0;
		step(4'h3, 4);
		expect_out(1'b1, 1'b0, 2'h1);
		step(4'h0, 4);
		expect_out(1'b1, 1'b0, 2'h1);
		// Mid-run reset while running, then a clean restart
		src = motor_cmd_pkg::SRC_DIGITAL;
		i_rst_n = 1'b0;
		step(4'h1, 3);
		expect_out(1'b0, 1'b0, 2'h0);
		i_rst_n = 1'b1;
		step(4'h1, 4);
		expect_out(1'b1, 1'b0, 2'h1);
		end_of_test();
	end
endmodule

`default_nettype wire
